// ### verilog/pvas_pkg.sv
// pvas_pkg: shared constants for the video adc sequencer
// assumes a single 200 MHz clock domain, no software registers
package pvas_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int COARSE_W = 4;
    localparam int FINE_W = 4;
    localparam int CODE_W = 8;
    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_RST = 8'h00;
    localparam int LATENCY_RISE = 3;
    localparam int BUF_DEPTH = 2;
    // comparator phase codes, one-hot
    typedef enum logic [2:0] {
        PVAS_SAMPLE = 3'b001,
        PVAS_HOLD = 3'b010,
        PVAS_COMPARE = 3'b100
    } pvas_phase_e;
endpackage

// ### verilog/pvas_skid.sv
// pvas_skid: two-entry buffer with valid/ready on both sides
// assumes one clock, async active-low reset
`timescale 1ns/1ps
module pvas_skid #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem_r [2];
    logic wp_r;
    logic rp_r;
    logic [1:0] cnt_r;
    logic push;
    logic pop;

    // ----------------------------------------------------------------
    // handshake
    // ----------------------------------------------------------------
    // a pop frees its slot on the same edge, so a full buffer that is
    // draining still takes the next word instead of dropping it
    assign in_ready = (cnt_r != 2'd2) || out_ready;
    assign out_valid = (cnt_r != 2'd0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage, no reset needed on data
    always_ff @(posedge mclk)
    begin
        if (push)
            mem_r[wp_r] <= in_data;
    end

    // pointers and fill level
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'd0;
        end
        else
        begin
            if (push)
                wp_r <= ~wp_r;
            if (pop)
                rp_r <= ~rp_r;
            cnt_r <= cnt_r + 2'(push) - 2'(pop);
        end
    end

    chk_no_overfill : assert property (@(posedge mclk) disable iff (!rst_b)
        cnt_r <= 2'd2)
        else $error("buffer count exceeds two");
endmodule // pvas_skid

// ### verilog/pvas_seq.sv
// pvas_seq: digital sequencing of a two-step pipelined video adc
// assumes comparator decisions arrive as synchronous thermometer inputs
`timescale 1ns/1ps
module pvas_seq (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // comparator decisions, thermometer, bit i high when input above step
    input wire logic [14:0] coarse_therm,
    input wire logic [14:0] fine_therm_a,
    input wire logic [14:0] fine_therm_b,
    // analog control
    output logic sample_hold_r,
    output logic [2:0] coarse_phase_r,
    output logic [2:0] fine_a_phase_r,
    output logic [2:0] fine_b_phase_r,
    output logic [3:0] fine_reference_level_r,
    output logic fine_sel_r,
    // output bus
    input wire logic output_enable_b,
    output logic [7:0] sample_data_bus_o_r,
    output logic sample_data_bus_oe_r,
    // receiver stall
    input wire logic rx_ready,
    output logic word_valid_r
);
    typedef pvas_pkg::pvas_phase_e phase_t;
    logic fall_r;
    logic [3:0] coarse_result_r;
    logic [3:0] fine_result_r;
    logic [2:0] pipe_v_r;
    logic buf_valid;
    logic buf_ready;
    logic [7:0] buf_data;
    logic [7:0] merged;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // thermometer count: used for coarse and both fine groups
    function automatic logic [3:0] therm2bin(input logic [14:0] t);
        logic [3:0] n;
        n = 4'd0;
        for (int i = 0; i < 15; i++)
            n = n + 4'(t[i]);
        return n;
    endfunction

    // next comparator phase in the three-step cycle
    function automatic phase_t next_phase(input phase_t p);
        phase_t q;
        q = pvas_pkg::PVAS_SAMPLE;
        unique case (p)
            pvas_pkg::PVAS_SAMPLE: q = pvas_pkg::PVAS_HOLD;
            pvas_pkg::PVAS_HOLD: q = pvas_pkg::PVAS_COMPARE;
            pvas_pkg::PVAS_COMPARE: q = pvas_pkg::PVAS_SAMPLE;
            default: q = pvas_pkg::PVAS_SAMPLE;
        endcase
        return q;
    endfunction

    // ----------------------------------------------------------------
    // sampling half-cycle
    // ----------------------------------------------------------------
    // each mclk cycle models one half-cycle of the analog clock; the low-going edge
    // is marked by fall_r so that all logic stays on rising edges
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            fall_r <= 1'b0;
        else
            fall_r <= ~fall_r;
    end

    // hold strobe: one capture per sampling period
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            sample_hold_r <= 1'b0;
        else
            sample_hold_r <= ~fall_r;
    end

    // ----------------------------------------------------------------
    // comparator phases
    // ----------------------------------------------------------------
    // coarse group cycles every sample; fine groups alternate
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            coarse_phase_r <= pvas_pkg::PVAS_SAMPLE;
            fine_a_phase_r <= pvas_pkg::PVAS_SAMPLE;
            fine_b_phase_r <= pvas_pkg::PVAS_COMPARE;
            fine_sel_r <= 1'b0;
        end
        else if (fall_r)
        begin
            coarse_phase_r <= next_phase(phase_t'(coarse_phase_r));
            fine_a_phase_r <= next_phase(phase_t'(fine_a_phase_r));
            fine_b_phase_r <= next_phase(phase_t'(fine_b_phase_r));
            fine_sel_r <= ~fine_sel_r;
        end
    end

    // ----------------------------------------------------------------
    // coarse then fine decisions
    // ----------------------------------------------------------------
    // coarse result and fine reference one edge after sampling
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            coarse_result_r <= 4'h0;
            fine_reference_level_r <= 4'h0;
        end
        else if (!fall_r)
        begin
            coarse_result_r <= therm2bin(coarse_therm);
            fine_reference_level_r <= therm2bin(coarse_therm);
        end
    end

    // fine result from the group that holds this sample
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            fine_result_r <= 4'h0;
        else if (fall_r)
            fine_result_r <= fine_sel_r ? therm2bin(fine_therm_b)
                                        : therm2bin(fine_therm_a);
    end

    // sample validity track through the pipe, one bit per stage
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            pipe_v_r <= 3'b000;
        else
            pipe_v_r <= {pipe_v_r[1:0], sample_hold_r};
    end

    // ----------------------------------------------------------------
    // merge, buffer and bus
    // ----------------------------------------------------------------
    // steps above bottom count up, so code rises with the input
    assign merged = {coarse_result_r, fine_result_r};

    pvas_skid #(
        .W(pvas_pkg::CODE_W)
    ) u_skid (
        .mclk(mclk),
        .rst_b(rst_b),
        .in_valid(pipe_v_r[2] && !fall_r),
        .in_ready(buf_ready),
        .in_data(merged),
        .out_valid(buf_valid),
        .out_ready(rx_ready && !fall_r),
        .out_data(buf_data)
    );

    // word presented on a rising edge, holds a full period
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sample_data_bus_o_r <= pvas_pkg::CODE_RST;
            word_valid_r <= 1'b0;
        end
        else if (!fall_r)
        begin
            sample_data_bus_o_r <= buf_valid ? buf_data
                                             : sample_data_bus_o_r;
            word_valid_r <= buf_valid && rx_ready;
        end
    end

    // drive only while the enable pin is held low
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            sample_data_bus_oe_r <= 1'b0;
        else
            sample_data_bus_oe_r <= !output_enable_b;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_oe_follows_pin : assert property (
        @(posedge mclk) disable iff (!rst_b)
        output_enable_b |=> !sample_data_bus_oe_r)
        else $error("bus driven while enable high");
    chk_word_stands : assert property (
        @(posedge mclk) disable iff (!rst_b)
        fall_r |=> $stable(sample_data_bus_o_r))
        else $error("output word changed mid period");
    chk_phase_cycle : assert property (
        @(posedge mclk) disable iff (!rst_b)
        fall_r && coarse_phase_r == pvas_pkg::PVAS_SAMPLE
        |=> coarse_phase_r == pvas_pkg::PVAS_HOLD)
        else $error("comparator phase out of order");
    chk_fine_alt : assert property (
        @(posedge mclk) disable iff (!rst_b)
        fall_r |=> fine_sel_r != $past(fine_sel_r))
        else $error("fine groups not alternating");
    chk_coarse_edge : assert property (
        @(posedge mclk) disable iff (!rst_b)
        !fall_r |=> coarse_result_r == therm2bin($past(coarse_therm)))
        else $error("coarse result not settled");
    chk_ref_tracks : assert property (
        @(posedge mclk) disable iff (!rst_b)
        fine_reference_level_r == coarse_result_r)
        else $error("fine reference differs from coarse");
    chk_fine_edge : assert property (
        @(posedge mclk) disable iff (!rst_b)
        fall_r && !fine_sel_r
        |=> fine_result_r == therm2bin($past(fine_therm_a)))
        else $error("fine result not settled");
    chk_sample_rate : assert property (
        @(posedge mclk) disable iff (!rst_b)
        sample_hold_r |=> !sample_hold_r ##1 sample_hold_r)
        else $error("sample strobe not once per period");
    chk_merge_order : assert property (
        @(posedge mclk) disable iff (!rst_b)
        merged[7:4] == coarse_result_r)
        else $error("coarse bits not on top");
endmodule // pvas_seq

// ### bench/pvas_rx_model.sv
// pvas_rx_model: downstream video logic reading the sample bus
// assumes the bench makes mclk; requests are copied on the falling edge
`timescale 1ns/1ps
module pvas_rx_model #(
    parameter int CLAMP_CYC = 550,
    parameter int LINE_CYC = 12698
) (
    // clock and bench requests
    input wire logic mclk,
    input wire logic oe_req,
    input wire logic stall_req,
    // converter side
    output logic output_enable_b,
    output logic rx_ready,
    input wire logic [7:0] bus_o,
    input wire logic bus_oe,
    output logic [7:0] bus_pin,
    output logic line_clamp_pulse
);
    logic [7:0] last_r = 8'h00;
    int line_cnt = 0;
    // known levels before the first edge
    initial
    begin
        output_enable_b = 1'b0;
        rx_ready = 1'b1;
    end
    // drive off the sampling edge so the converter sees settled levels
    always @(negedge mclk)
    begin
        output_enable_b <= oe_req;
        rx_ready <= !stall_req;
    end
    // released bus shows the inverse, so a stale hold never passes
    assign bus_pin = bus_oe ? bus_o : ~last_r;
    // clamp kept registered on mclk, avoids beat against the sample rate
    always @(posedge mclk)
    begin
        if (bus_oe)
            last_r <= bus_o;
        line_cnt <= (line_cnt + 1) % LINE_CYC;
        line_clamp_pulse <= !(line_cnt < CLAMP_CYC);
    end
endmodule // pvas_rx_model

// ### bench/tb_top.sv
// tb_top: self-checking bench for the video adc sequencer
// assumes pvas_pkg, pvas_skid, pvas_seq and pvas_rx_model compiled first
`timescale 1ns/1ps
module tb_top;
    logic mclk = 0;
    logic rst_b = 0;
    logic [14:0] coarse_therm = '0;
    logic [14:0] fine_therm_a = '0;
    logic [14:0] fine_therm_b = '0;
    logic oe_req = 0;
    logic stall_req = 0;
    logic output_enable_b, rx_ready, sample_hold_r, fine_sel_r, word_valid_r;
    logic sample_data_bus_oe_r, line_clamp_pulse, sh_q, fs_q, fs_q2, oe_q;
    logic took = 0;
    logic [2:0] coarse_phase_r, fine_a_phase_r, fine_b_phase_r;
    logic [3:0] fine_reference_level_r;
    logic [7:0] sample_data_bus_o_r, bus_pin, bus_q, e, cur = 8'h00;
    logic [7:0] stim_q[$], exp_q[$];
    logic [7:0] edges[8] = '{8'hff, 8'h00, 8'h80, 8'h7f, 8'hf0, 8'h0f,
        8'h01, 8'hfe};
    int exp_t[$];
    int t, cyc = 0, bad_count = 0, checks = 0;
    bit lat_on = 1;
    // sample edge sits half a period before the first rising period edge
    localparam int LAT_CYC = 2 * pvas_pkg::LATENCY_RISE - 1;
    initial
        forever #2.5 mclk = ~mclk;
    pvas_seq dut (.mclk, .rst_b, .coarse_therm, .fine_therm_a, .fine_therm_b,
        .sample_hold_r, .coarse_phase_r, .fine_a_phase_r, .fine_b_phase_r,
        .fine_reference_level_r, .fine_sel_r, .output_enable_b,
        .sample_data_bus_o_r, .sample_data_bus_oe_r, .rx_ready, .word_valid_r);
    pvas_rx_model rx (.mclk, .oe_req, .stall_req, .output_enable_b, .rx_ready,
        .bus_o(sample_data_bus_o_r), .bus_oe(sample_data_bus_oe_r), .bus_pin,
        .line_clamp_pulse);
    // ----------
    // helpers
    // ----------
    function automatic logic [14:0] therm(logic [3:0] v);
        return 15'((16'h0001 << v) - 16'h0001);
    endfunction
    function automatic logic [7:0] ok3(logic [2:0] c, a, b);
        return {7'h00, (c inside {3'b001, 3'b010, 3'b100})
            && (a inside {3'b001, 3'b010, 3'b100})
            && (b inside {3'b001, 3'b010, 3'b100})};
    endfunction
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rst_vals();
        check("rst bus", sample_data_bus_o_r, pvas_pkg::CODE_RST);
        check("rst flags", {fine_reference_level_r, word_valid_r,
            sample_data_bus_oe_r, fine_sel_r, sample_hold_r}, 8'h00);
        check("rph", {2'h0, coarse_phase_r, fine_a_phase_r}, 8'h09);
        check("rst ph b", {5'h00, fine_b_phase_r}, 8'h04);
    endtask
    task automatic drain();
        repeat (200)
            if (stim_q.size() > 0)
                @(negedge mclk);
        repeat (16)
            @(negedge mclk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ----------
    // stimulus and scoreboard
    // ----------
    always @(posedge mclk or negedge rst_b)
        if (!rst_b)
            cyc <= 0;
        else
            cyc <= cyc + 1;
    // converter samples every period, so a word is always expected;
    // levels change after the fall edge so coarse is taken before fine
    always @(negedge mclk)
        if (rst_b && cyc > 0 && !cyc[0])
        begin
            if (stim_q.size() > 0)
                cur = stim_q.pop_front();
            coarse_therm <= therm(cur[7:4]);
            fine_therm_a <= therm(cur[3:0]);
            fine_therm_b <= therm(cur[3:0]);
            exp_q.push_back(cur);
            exp_t.push_back(cyc);
        end
    // words are two cycles long: take the first, check the second
    always @(posedge mclk)
    begin
        if (!rst_b)
        begin
            exp_q.delete();
            exp_t.delete();
            took <= 0;
        end
        else if (cyc > 4)
        begin
            check("hold", {7'h00, sample_hold_r ^ sh_q}, 8'h01);
            e = ok3(coarse_phase_r, fine_a_phase_r, fine_b_phase_r);
            check("phase", e, 8'h01);
            check("group", {7'h00, fine_sel_r ^ fs_q2}, 8'h01);
            check("enable", 8'(sample_data_bus_oe_r), 8'(!oe_q));
            if (sample_data_bus_oe_r)
                check("pin", bus_pin, sample_data_bus_o_r);
            if (took)
                check("stand", sample_data_bus_o_r, bus_q);
            if (word_valid_r && !took)
            begin
                e = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
                t = exp_t.size() > 0 ? exp_t.pop_front() : 0;
                check("word", sample_data_bus_o_r, e);
                if (lat_on)
                    check("latency", 8'(cyc - t), 8'(LAT_CYC));
            end
            took <= word_valid_r && !took;
        end
        sh_q <= sample_hold_r;
        fs_q <= fine_sel_r;
        fs_q2 <= fs_q;
        oe_q <= output_enable_b;
        bus_q <= sample_data_bus_o_r;
    end
    initial
    begin
        void'($urandom(32'h3864_00e7));
        repeat (8) @(posedge mclk);
        rst_vals();
        @(negedge mclk);
        rst_b = 1;
        foreach (edges[i]) stim_q.push_back(edges[i]);
        drain();
        $display("test boundary codes done");
        repeat (24) stim_q.push_back(8'($urandom));
        repeat (12)
        begin
            repeat (3) @(negedge mclk);
            oe_req <= !oe_req;
        end
        // an even count of toggles leaves the bus driven
        drain();
        $display("test random codes with bus release done");
        // buffered words add delay, so latency is not judged here
        lat_on = 0;
        repeat (8) stim_q.push_back(8'($urandom));
        repeat (4) @(negedge mclk);
        stall_req <= 1;
        // one period of stall: the spare buffer slot absorbs one word
        repeat (2) @(negedge mclk);
        stall_req <= 0;
        drain();
        $display("test receiver stall done");
        @(negedge mclk);
        if (!cyc[0])
            @(negedge mclk);
        rst_b = 0;
        @(negedge mclk);
        rst_vals();
        @(negedge mclk);
        rst_b = 1;
        lat_on = 1;
        repeat (4) stim_q.push_back(8'($urandom));
        drain();
        $display("test second reset done");
        tally_and_finish();
    end
    initial
    begin
        #20000;
        bad_count++;
        tally_and_finish();
    end
endmodule // tb_top
